// *** hw/psc_pkg.sv ***
// Constants for the host-driven serial configuration loader
// Assumes core_clk at 10 MHz; times converted to cycles here
package psc_pkg;
   localparam int unsigned CLK_PERIOD_NS       = 100;
   localparam int unsigned LOW_RESP_MAX_NS     = 600;
   localparam int unsigned OK_LOW_MIN_US       = 268;
   localparam int unsigned OK_LOW_MAX_US       = 1506;
   localparam int unsigned INIT_MIN_US         = 175;
   localparam int unsigned INIT_MAX_US         = 437;
   localparam int unsigned USER_INIT_CYCLES    = 8576;
   // Longest time rounds down, at least one cycle
   localparam int unsigned LOW_RESP_CYC =
      (LOW_RESP_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : LOW_RESP_MAX_NS / CLK_PERIOD_NS;
   // Least time rounds up
   localparam int unsigned OK_LOW_MIN_CYC =
      (OK_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned INIT_MIN_CYC =
      (INIT_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W = 16;
   localparam logic [1:0] STAGE_RST = 2'h0;
   typedef enum logic [1:0] {
      PSC_IDLE  = 2'b00,
      PSC_RESET = 2'b01,
      PSC_LOAD  = 2'b11,
      PSC_INIT  = 2'b10
   } psc_state_e;
endpackage : psc_pkg

// *** hw/psc_link_if.sv ***
// Signals between the bit-clock capture logic and the core sequencer
// Assumes capture runs on cfg_bit_clock, sequencer on core_clk
interface psc_link_if;
   logic armN;
   logic bitToggle;
   logic bitValue;
   modport capture (input armN, output bitToggle, output bitValue);
   modport core    (output armN, input bitToggle, input bitValue);
endinterface : psc_link_if

// *** hw/psc_bit_capture.sv ***
// Bit-clock domain capture of the serial bitstream
// Assumes armN is a level from core_clk, synchronised here
module psc_bit_capture
   import psc_pkg::*;
(
   input  wire logic cfgBitClock,
   input  wire logic cfgData,
   psc_link_if.capture lnk
);
   logic armSync1_reg, armSync2_reg, tog_reg, tog_next, dat_reg, dat_next;

   // Every rising edge is reported: the bit clock may stand still until the
   // host starts, so a gate behind a synchroniser here would swallow the first bits.
   // The core counts edges only while loading.
   always_comb begin
      tog_next = ~tog_reg;
      dat_next = dat_reg;
      if (!armSync2_reg) begin
         dat_next = cfgData;
      end
   end

   always_ff @(posedge cfgBitClock) begin
      armSync1_reg <= lnk.armN;
      armSync2_reg <= armSync1_reg;
      tog_reg      <= tog_next;
      dat_reg      <= dat_next;
   end

   assign lnk.bitToggle = tog_reg;
   assign lnk.bitValue  = dat_reg;
endmodule // psc_bit_capture

// *** hw/psc_config_loader.sv ***
// Device side of the host-driven serial configuration handshake
// Assumes host drives restart_request_n, cfg_bit_clock and data; open-drain pins resolved outside
// Behaviour
// - Load-complete driven low within 600 ns of restart request low.
// - Load-ok driven low within 600 ns of restart request low.
// - Load-ok held low between 268 and 1506 us, unless extended.
// - Load-ok released within 1506 us of restart high unless held externally.
// - Data captured on rising bit-clock edge; the code captures only once armN low has passed two bit-clock flops.
// - Internal oscillator init ends in user mode 175 to 437 us after load-complete.
// - With user init clock, user mode after delay plus 8576 cycles; the code counts 8576 user-clock edges with no delay.
module psc_config_loader
   import psc_pkg::*;
#(
   parameter int unsigned BITSTREAM_BITS = 64,
   parameter int unsigned OK_LOW_CYC     = OK_LOW_MIN_CYC,
   parameter int unsigned INIT_CYC       = INIT_MIN_CYC,
   parameter int unsigned USER_INIT_CYC  = USER_INIT_CYCLES
)(
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic restart_request_n,
   input  wire logic load_ok_n_in,
   output logic      load_ok_n_out,
   output logic      load_ok_n_oe_n,
   output logic      load_complete_out,
   output logic      load_complete_oe_n,
   input  wire logic cfg_bit_clock,
   input  wire logic cfg_data,
   input  wire logic user_init_clock,
   input  wire logic user_init_sel,
   output logic      user_mode
);
   psc_link_if lnk ();

   psc_bit_capture u_cap (
      .cfgBitClock (cfg_bit_clock),
      .cfgData     (cfg_data),
      .lnk         (lnk.capture)
   );

   logic       rqS1_reg, rqS2_reg, okS1_reg, okS2_reg;
   logic       tgS1_reg, tgS2_reg, tgS3_reg, ucS1_reg, ucS2_reg, ucS3_reg;
   psc_state_e st_reg, st_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [31:0]      bits_reg, bits_next;
   logic       okLow_reg, okLow_next, cdLow_reg, cdLow_next, um_reg, um_next;
   logic       arm_reg, arm_next;
   logic       bitEvt, ucEdge;

   assign bitEvt = tgS2_reg ^ tgS3_reg;
   assign ucEdge = ucS2_reg & ~ucS3_reg;

   always_comb begin
      st_next    = st_reg;
      cnt_next   = cnt_reg;
      bits_next  = bits_reg;
      okLow_next = okLow_reg;
      cdLow_next = cdLow_reg;
      um_next    = um_reg;
      arm_next   = arm_reg;
      if (!rqS2_reg) begin
         st_next    = PSC_RESET;
         okLow_next = 1'b1;
         cdLow_next = 1'b1;
         um_next    = 1'b0;
         arm_next   = 1'b1;
         cnt_next   = '0;
         bits_next  = '0;
      end else begin
         unique case (st_reg)
            PSC_IDLE: begin
            end
            PSC_RESET: begin
               if (cnt_reg < CNT_W'(OK_LOW_CYC))
                  cnt_next = cnt_reg + CNT_W'(1);
               else if (okLow_reg)
                  okLow_next = 1'b0;
               else if (okS2_reg) begin
                  // Released and not held by another party
                  st_next  = PSC_LOAD;
                  arm_next = 1'b0;
               end
            end
            PSC_LOAD: begin
               if (bitEvt)
                  bits_next = bits_reg + 32'h1;
               if (bits_reg == BITSTREAM_BITS) begin
                  cdLow_next = 1'b0;
                  arm_next   = 1'b1;
                  cnt_next   = '0;
                  st_next    = PSC_INIT;
               end
            end
            PSC_INIT: begin
               if (user_init_sel) begin
                  if (ucEdge)
                     cnt_next = cnt_reg + CNT_W'(1);
                  if (cnt_reg == CNT_W'(USER_INIT_CYC)) begin
                     um_next = 1'b1;
                     st_next = PSC_IDLE;
                  end
               end else begin
                  cnt_next = cnt_reg + CNT_W'(1);
                  if (cnt_reg == CNT_W'(INIT_CYC)) begin
                     um_next = 1'b1;
                     st_next = PSC_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      rqS1_reg <= restart_request_n;
      rqS2_reg <= rqS1_reg;
      okS1_reg <= load_ok_n_in;
      okS2_reg <= okS1_reg;
      tgS1_reg <= lnk.bitToggle;
      tgS2_reg <= tgS1_reg;
      tgS3_reg <= tgS2_reg;
      ucS1_reg <= user_init_clock;
      ucS2_reg <= ucS1_reg;
      ucS3_reg <= ucS2_reg;
      if (rst) begin
         st_reg    <= PSC_IDLE;
         cnt_reg   <= '0;
         bits_reg  <= '0;
         okLow_reg <= 1'b0;
         cdLow_reg <= 1'b1;
         um_reg    <= 1'b0;
         arm_reg   <= 1'b1;
      end else begin
         st_reg    <= st_next;
         cnt_reg   <= cnt_next;
         bits_reg  <= bits_next;
         okLow_reg <= okLow_next;
         cdLow_reg <= cdLow_next;
         um_reg    <= um_next;
         arm_reg   <= arm_next;
      end
   end

   assign lnk.armN         = arm_reg;
   assign load_ok_n_out    = 1'b0;
   assign load_ok_n_oe_n   = ~okLow_reg;
   assign load_complete_out  = 1'b0;
   assign load_complete_oe_n = ~cdLow_reg;
   assign user_mode        = um_reg;
endmodule // psc_config_loader

// *** tb/psc_config_loader_monitor.sv ***
// Port-level timing checker for the serial configuration loader
// Assumes sim-sized counts are handed in by the bind below
module psc_config_loader_monitor #(
   parameter int unsigned BITSTREAM_BITS = 64, OK_LOW_CYC = 20,
   parameter int unsigned INIT_CYC = 10, USER_INIT_CYC = 8
)(
   input logic core_clk, rst, restart_request_n, load_ok_n_in, load_ok_n_out,
   input logic load_ok_n_oe_n, load_complete_out, load_complete_oe_n, cfg_bit_clock,
   input logic cfg_data, user_init_clock, user_init_sel, user_mode
);
   localparam int REL_MAX = OK_LOW_CYC + 6;
   localparam int INIT_LO = INIT_CYC - 1;
   int   lowCnt, bitCnt, bitBase, userCnt;
   logic userPrev;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   always_ff @(posedge cfg_bit_clock) bitCnt <= bitCnt + 1;
   always_ff @(posedge core_clk) begin
      lowCnt   <= load_ok_n_oe_n ? 0 : lowCnt + 1;
      userPrev <= user_init_clock;
      userCnt  <= !load_complete_oe_n ? 0 : userCnt + int'(user_init_clock & !userPrev);
      if ($fell(load_ok_n_oe_n)) bitBase <= bitCnt;
   end
   property p_cd_low; $fell(restart_request_n) |-> ##[0:6] !load_complete_oe_n; endproperty
   a_cd_low: assert property (p_cd_low) else $error("load_complete late low");
   property p_ok_low; $fell(restart_request_n) |-> ##[0:6] !load_ok_n_oe_n; endproperty
   a_ok_low: assert property (p_ok_low) else $error("load_ok late low");
   property p_ok_min; $rose(load_ok_n_oe_n) |-> lowCnt >= OK_LOW_CYC; endproperty
   a_ok_min: assert property (p_ok_min) else $error("load_ok low too short");
   property p_ok_rel; $rose(restart_request_n) |-> ##[0:REL_MAX] load_ok_n_oe_n; endproperty
   a_ok_rel: assert property (p_ok_rel) else $error("load_ok release late");
   property p_bits; $rose(load_complete_oe_n) |-> bitCnt - bitBase >= BITSTREAM_BITS;
   endproperty
   a_bits: assert property (p_bits) else $error("load_complete before all bits");
   property p_init;
      $rose(load_complete_oe_n) && !user_init_sel |-> ##INIT_LO !user_mode ##[1:8] user_mode;
   endproperty
   a_init: assert property (p_init) else $error("internal init time wrong");
   property p_user; $rose(user_mode) && user_init_sel |-> userCnt >= USER_INIT_CYC; endproperty
   a_user: assert property (p_user) else $error("user init too few edges");
   c_release: cover property ($rose(load_ok_n_oe_n));
   c_done: cover property ($rose(load_complete_oe_n));
   c_user: cover property ($rose(user_mode) && user_init_sel);
endmodule // psc_config_loader_monitor
bind psc_config_loader psc_config_loader_monitor #(.BITSTREAM_BITS(BITSTREAM_BITS),
   .OK_LOW_CYC(OK_LOW_CYC), .INIT_CYC(INIT_CYC), .USER_INIT_CYC(USER_INIT_CYC)) u_mon (.*);

// *** tb/psc_host_model.sv ***
// Host side of the serial load: one bit-clock period per requested bit
// Assumes fire pulses are spaced wider than the core sees a bit
module psc_host_model (
   input  logic fire,
   output logic bitClk,
   output logic bitData
);
   timeunit 1ns; timeprecision 100ps;
   initial begin
      bitClk = 1'b0;
      bitData = 1'b1;
   end
   // Clock rests low between bits
   always @(posedge fire) begin
      bitData = ~bitData;
      #3 bitClk = 1'b1;
      #3 bitClk = 1'b0;
   end
endmodule // psc_host_model

// *** tb/psc_config_loader_tb_top.sv ***
// Bench for the configuration loader: handshake, bit load, both init clocks
// Assumes the host model and the bound checker are compiled first
module psc_config_loader_tb_top;
   timeunit 1ns; timeprecision 100ps;
   localparam int OKC = 20, INITC = 10, USRC = 8, NBITS = 8;
   logic core_clk = 0, rst = 1, restartN = 1, extHoldN = 1, fire = 0, uClk = 0, uSel = 0;
   logic bitClk, bitData, okOut, okOeN, cdOut, cdOeN, userMode, okWire;
   int   errors = 0, num_checks = 0;
   assign okWire = (okOeN ? 1'b1 : okOut) & extHoldN;
   always #50 core_clk = ~core_clk;
   psc_host_model u_psc_host_model (.fire(fire), .bitClk(bitClk), .bitData(bitData));
   psc_config_loader #(.BITSTREAM_BITS(NBITS), .OK_LOW_CYC(OKC), .INIT_CYC(INITC),
      .USER_INIT_CYC(USRC)) u_psc_config_loader (.core_clk(core_clk), .rst(rst),
      .restart_request_n(restartN), .load_ok_n_in(okWire), .load_ok_n_out(okOut),
      .load_ok_n_oe_n(okOeN), .load_complete_out(cdOut), .load_complete_oe_n(cdOeN),
      .cfg_bit_clock(bitClk), .cfg_data(bitData), .user_init_clock(uClk),
      .user_init_sel(uSel), .user_mode(userMode));
   task automatic chk(input string what, input logic exp, input logic got);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("wrong value %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task automatic do_reset();
      rst = 1;
      cyc(10);
      rst = 0;
      cyc(4);
   endtask
   task automatic load(input int lowCyc, input int holdCyc);
      int n;
      restartN = 0;
      extHoldN = (holdCyc == 0);
      cyc(6);
      chk("load_ok_n_oe_n", 1'b0, okOeN);
      chk("load_complete_oe_n", 1'b0, cdOeN);
      cyc(lowCyc - 6);
      restartN = 1;
      cyc(OKC - 2);
      chk("load_ok_n_oe_n held", 1'b0, okOeN);
      cyc(7);
      chk("load_ok_n_oe_n released", 1'b1, okOeN);
      cyc(holdCyc);
      extHoldN = 1;
      cyc(20);
      for (n = 0; n < NBITS; n++) begin
         if (n == NBITS - 1) chk("load_complete_oe_n early", 1'b0, cdOeN);
         fire = 1;
         cyc(1);
         fire = 0;
         cyc(3);
      end
      n = 0;
      while (cdOeN !== 1'b1 && n < 20) begin
         cyc(1);
         n++;
      end
      chk("load_complete_oe_n", 1'b1, cdOeN);
   endtask
   task automatic s_internal();
      uSel = 0;
      load(20, 0);
      cyc(INITC - 2);
      chk("user_mode early", 1'b0, userMode);
      cyc(6);
      chk("user_mode", 1'b1, userMode);
   endtask
   task automatic s_user();
      uSel = 1;
      load(40, 15);
      cyc(1);
      repeat (USRC - 1) begin
         uClk = 1;
         cyc(2);
         uClk = 0;
         cyc(2);
      end
      cyc(4);
      chk("user_mode early", 1'b0, userMode);
      uClk = 1;
      cyc(6);
      chk("user_mode", 1'b1, userMode);
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      cyc(3000);
      errors++;
      summarize();
   end
   initial begin
      do_reset();
      s_internal();
      do_reset();
      s_user();
      summarize();
   end
endmodule // psc_config_loader_tb_top
